/* rtl/tpsc_serial_ctrl.sv */
// Serial-bus slave that loads the synthesizer divider, control and band settings
//
// Contract
// - Address last bit zero writes, one reads
// - Accepts written bytes, returns status when read
// - Answers one of four pin-selected addresses
// - Pulls data low to acknowledge matched address
// - Acknowledges every accepted write data byte
// - Address, divider pair, control, then band byte
// - Latch at end of bytes three, four, five
// - Divider word updates only as complete pair
// - First bit zero divider, one control/band
// - More bytes accepted without address until stop
// - Aborted transfer keeps fully latched settings
// - Fifteen-bit divider sets total division ratio
// - Reference divide 64, 80, 24 or 28
// - Control bit two selects pump current
// - Control bits three to five select test
// - Control bits six, seven select reference divider
// - Control bit eight disables amp, forces sink
// - Codes 00,01,10,11 give 80,28,24,64
// - Test code decode: off, sink, source, outputs
// - Address prefix 11000, hardware bits, direction bit
`timescale 1ns/1ps
module tpsc_serial_ctrl (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic [1:0]  addr_sel_in,
	input  wire logic        lock_in,
	output logic [14:0]      divider_word,
	output logic [7:0]       function_control_byte,
	output logic [3:0]       band_port,
	output logic             pump_current_select,
	output logic             test_select_hi,
	output logic             test_select_mid,
	output logic             test_select_lo,
	output logic [1:0]       ref_div_select,
	output logic [6:0]       ref_divide_ratio,
	output logic             tuning_amp_disable,
	output logic             pump_off,
	output logic             pump_sink_only,
	output logic             pump_source_only,
	output logic             ref_signal_out_en,
	output logic             half_counter_out_en,
	output logic             por_flag
);

	// ----------------------------------------
	// Pin conditioning and byte assembly
	// ----------------------------------------
	tpsc_line_if line ();

	logic        rx_full;     // Byte complete pulse
	logic [7:0]  rx_byte;     // Byte just received
	logic        shift_en;    // Take a bit on this rising clock edge
	logic        shift_clr;   // Realign the bit counter
	logic        addr_match;  // Address byte is ours
	logic        rx_done;     // Write data byte complete

	tpsc_pin_sync u_sync (
		.clk         (clk),
		.reset       (reset),
		.clk_en      (clk_en),
		.scl_in      (scl_in),
		.sda_in      (sda_in),
		.lock_in     (lock_in),
		.addr_sel_in (addr_sel_in),
		.line        (line.src)
	);

	tpsc_rx_shift #(.WIDTH(tpsc_pkg::BYTE_W)) u_shift (
		.clk      (clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.clear    (shift_clr),
		.shift_en (shift_en),
		.bit_in   (line.sda_lvl),
		.data     (rx_byte),
		.full     (rx_full)
	);

	// ----------------------------------------
	// Protocol state
	// ----------------------------------------
	tpsc_pkg::tpsc_state_e state_ff;    // Bus phase
	logic                  ack_pend_ff; // Acknowledge due at next falling edge
	logic                  rw_ff;       // Latched direction bit
	logic [7:0]            tx_ff;       // Status byte being sent
	logic [2:0]            tx_cnt_ff;   // Status bits already sent
	logic                  mack_ff;     // Master acknowledged last status byte
	logic                  drive_ff;    // Pulling the data line low
	logic                  por_ff;      // Power-on flag
	tpsc_pkg::tpsc_state_e nxt_state;
	logic                  nxt_ack_pend;
	logic                  nxt_rw;
	logic [7:0]            nxt_tx;
	logic [2:0]            nxt_tx_cnt;
	logic                  nxt_mack;
	logic                  nxt_drive;
	logic                  nxt_por;
	logic [7:0]            status_byte;

	// Prefix and pin-selected bits must both agree
	assign addr_match = (rx_byte[7:tpsc_pkg::ADDR_PREFIX_LSB] == tpsc_pkg::ADDR_PREFIX)
		&& (rx_byte[tpsc_pkg::ADDR_HW_LSB+1:tpsc_pkg::ADDR_HW_LSB] == line.hw_addr);
	assign status_byte = {por_ff, line.lock_lvl, tpsc_pkg::STATUS_ONES};
	// Bits only shift while a byte is being read in, never in an ack slot
	assign shift_en  = line.scl_rise && !ack_pend_ff && (state_ff == tpsc_pkg::ST_ADDR || state_ff == tpsc_pkg::ST_RX);
	assign shift_clr = line.start_det || line.stop_det || (state_ff == tpsc_pkg::ST_ACK && line.scl_fall);
	assign rx_done   = rx_full && state_ff == tpsc_pkg::ST_RX;

	// Next protocol state; stop and start override everything
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_ack_pend = ack_pend_ff;
		nxt_rw       = rw_ff;
		nxt_tx       = tx_ff;
		nxt_tx_cnt   = tx_cnt_ff;
		nxt_mack     = mack_ff;
		nxt_drive    = drive_ff;
		nxt_por      = por_ff;
		if (line.stop_det)
		begin
			// Settings already latched stay; only the bus phase ends
			nxt_state    = tpsc_pkg::ST_IDLE;
			nxt_ack_pend = 1'b0;
			nxt_drive    = 1'b0;
		end
		else if (line.start_det)
		begin
			nxt_state    = tpsc_pkg::ST_ADDR;
			nxt_ack_pend = 1'b0;
			nxt_drive    = 1'b0;
		end
		else
		begin
			case (state_ff)
				tpsc_pkg::ST_ADDR:
				begin
					if (rx_full && addr_match)
					begin
						nxt_ack_pend = 1'b1;
						nxt_rw       = rx_byte[tpsc_pkg::ADDR_RW_BIT];
					end
					else if (rx_full)
						nxt_state = tpsc_pkg::ST_IDLE;
					else if (ack_pend_ff && line.scl_fall)
					begin
						nxt_ack_pend = 1'b0;
						nxt_drive    = 1'b1;
						nxt_state    = tpsc_pkg::ST_ACK;
					end
				end
				tpsc_pkg::ST_RX:
				begin
					// Every write byte is taken, so every one is acknowledged
					if (rx_full)
						nxt_ack_pend = 1'b1;
					else if (ack_pend_ff && line.scl_fall)
					begin
						nxt_ack_pend = 1'b0;
						nxt_drive    = 1'b1;
						nxt_state    = tpsc_pkg::ST_ACK;
					end
				end
				tpsc_pkg::ST_ACK:
				begin
					if (line.scl_fall && rw_ff)
					begin
						// Read: first status bit goes out as the slot ends
						nxt_state  = tpsc_pkg::ST_TX;
						nxt_tx     = status_byte;
						nxt_tx_cnt = 3'h0;
						nxt_drive  = !status_byte[7];
					end
					else if (line.scl_fall)
					begin
						nxt_state = tpsc_pkg::ST_RX;
						nxt_drive = 1'b0;
					end
				end
				tpsc_pkg::ST_TX:
				begin
					if (line.scl_fall && tx_cnt_ff == 3'h7)
					begin
						// Whole status byte sent, so the power-on flag is reported
						nxt_state = tpsc_pkg::ST_TXACK;
						nxt_drive = 1'b0;
						nxt_por   = 1'b0;
					end
					else if (line.scl_fall)
					begin
						nxt_tx     = {tx_ff[6:0], 1'b0};
						nxt_tx_cnt = tx_cnt_ff + 3'h1;
						nxt_drive  = !tx_ff[6];
					end
				end
				tpsc_pkg::ST_TXACK:
				begin
					if (line.scl_rise)
						nxt_mack = !line.sda_lvl;
					else if (line.scl_fall && mack_ff)
					begin
						// Master wants more: repeat a fresh status byte
						nxt_state  = tpsc_pkg::ST_TX;
						nxt_tx     = status_byte;
						nxt_tx_cnt = 3'h0;
						nxt_drive  = !status_byte[7];
					end
					else if (line.scl_fall)
						nxt_state = tpsc_pkg::ST_IDLE;
				end
				default:
					nxt_state = tpsc_pkg::ST_IDLE;
			endcase
		end
	end

	// Register the protocol state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_ff    <= tpsc_pkg::ST_IDLE;
			ack_pend_ff <= 1'b0;
			rw_ff       <= 1'b0;
			tx_ff       <= 8'h00;
			tx_cnt_ff   <= 3'h0;
			mack_ff     <= 1'b0;
			drive_ff    <= 1'b0;
			por_ff      <= tpsc_pkg::POR_RESET;
		end
		else if (clk_en)
		begin
			state_ff    <= nxt_state;
			ack_pend_ff <= nxt_ack_pend;
			rw_ff       <= nxt_rw;
			tx_ff       <= nxt_tx;
			tx_cnt_ff   <= nxt_tx_cnt;
			mack_ff     <= nxt_mack;
			drive_ff    <= nxt_drive;
			por_ff      <= nxt_por;
		end
	end

	// Open-drain: only ever pull low, enable is active low
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~drive_ff;
	assign por_flag = por_ff;

	// ----------------------------------------
	// Settings registers
	// ----------------------------------------
	tpsc_pkg::tpsc_phase_e phase_ff;   // Which byte the next data byte is
	logic [6:0]            div_hi_ff;  // Upper divider bits held until pair ends
	logic [14:0]           div_ff;     // Divider word
	logic [7:0]            ctrl_ff;    // Control byte
	logic [3:0]            band_ff;    // Band port bits
	logic [4:0]            dec_ff;     // Test-mode decode
	logic [6:0]            ratio_ff;   // Reference divide ratio
	tpsc_pkg::tpsc_phase_e nxt_phase;
	logic [6:0]            nxt_div_hi;
	logic [14:0]           nxt_div;
	logic [7:0]            nxt_ctrl;
	logic [3:0]            nxt_band;
	logic [4:0]            nxt_dec;
	logic [6:0]            nxt_ratio;
	logic [2:0]            tsel;
	logic                  os_bit;

	// Byte sorting and latching; decodes follow the latched control byte
	always_comb
	begin
		nxt_phase  = phase_ff;
		nxt_div_hi = div_hi_ff;
		nxt_div    = div_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_band   = band_ff;
		// A new address or a stop forgets a half-received divider pair
		if (line.start_det || line.stop_det)
			nxt_phase = tpsc_pkg::PH_CLASS;
		else if (rx_done)
		begin
			case (phase_ff)
				tpsc_pkg::PH_DIV2:
				begin
					// Both halves land together
					nxt_div   = {div_hi_ff, rx_byte};
					nxt_phase = tpsc_pkg::PH_CLASS;
				end
				tpsc_pkg::PH_BAND:
				begin
					nxt_band  = rx_byte[tpsc_pkg::BAND_W-1:0];
					nxt_phase = tpsc_pkg::PH_CLASS;
				end
				default:
				begin
					if (!rx_byte[tpsc_pkg::TYPE_BIT])
					begin
						nxt_div_hi = rx_byte[6:0];
						nxt_phase  = tpsc_pkg::PH_DIV2;
					end
					else
					begin
						nxt_ctrl  = rx_byte;
						nxt_phase = tpsc_pkg::PH_BAND;
					end
				end
			endcase
		end
		tsel   = {nxt_ctrl[tpsc_pkg::T2_BIT], nxt_ctrl[tpsc_pkg::T1_BIT], nxt_ctrl[tpsc_pkg::T0_BIT]};
		os_bit = nxt_ctrl[tpsc_pkg::OS_BIT];
		// Amp disable forces sink and blocks off and source only; ref and half still follow the test code
		nxt_dec[tpsc_pkg::DEC_OFF]  = !os_bit && tsel[2:1] == 2'h1;
		nxt_dec[tpsc_pkg::DEC_SINK] = os_bit || tsel == 3'h6;
		nxt_dec[tpsc_pkg::DEC_SRC]  = !os_bit && tsel == 3'h7;
		nxt_dec[tpsc_pkg::DEC_REF]  = tsel == 3'h4;
		nxt_dec[tpsc_pkg::DEC_HALF] = tsel == 3'h5;
		case (nxt_ctrl[tpsc_pkg::RSA_BIT:tpsc_pkg::RSB_BIT])
			2'h0:    nxt_ratio = tpsc_pkg::RATIO_00;
			2'h1:    nxt_ratio = tpsc_pkg::RATIO_01;
			2'h2:    nxt_ratio = tpsc_pkg::RATIO_10;
			default: nxt_ratio = tpsc_pkg::RATIO_11;
		endcase
	end

	// Register the settings
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			phase_ff  <= tpsc_pkg::PH_CLASS;
			div_hi_ff <= 7'h00;
			div_ff    <= tpsc_pkg::DIV_RESET;
			ctrl_ff   <= tpsc_pkg::CTRL_RESET;
			band_ff   <= tpsc_pkg::BAND_RESET;
			dec_ff    <= 5'h08;
			ratio_ff  <= tpsc_pkg::RATIO_11;
		end
		else if (clk_en)
		begin
			phase_ff  <= nxt_phase;
			div_hi_ff <= nxt_div_hi;
			div_ff    <= nxt_div;
			ctrl_ff   <= nxt_ctrl;
			band_ff   <= nxt_band;
			dec_ff    <= nxt_dec;
			ratio_ff  <= nxt_ratio;
		end
	end

	assign divider_word          = div_ff;
	assign function_control_byte = ctrl_ff;
	assign band_port             = band_ff;
	assign pump_current_select   = ctrl_ff[tpsc_pkg::CP_BIT];
	assign test_select_hi        = ctrl_ff[tpsc_pkg::T2_BIT];
	assign test_select_mid       = ctrl_ff[tpsc_pkg::T1_BIT];
	assign test_select_lo        = ctrl_ff[tpsc_pkg::T0_BIT];
	assign ref_div_select        = ctrl_ff[tpsc_pkg::RSA_BIT:tpsc_pkg::RSB_BIT];
	assign ref_divide_ratio      = ratio_ff;
	assign tuning_amp_disable    = ctrl_ff[tpsc_pkg::OS_BIT];
	assign pump_off              = dec_ff[tpsc_pkg::DEC_OFF];
	assign pump_sink_only        = dec_ff[tpsc_pkg::DEC_SINK];
	assign pump_source_only      = dec_ff[tpsc_pkg::DEC_SRC];
	assign ref_signal_out_en     = dec_ff[tpsc_pkg::DEC_REF];
	assign half_counter_out_en   = dec_ff[tpsc_pkg::DEC_HALF];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_addr_ack_drive: assert property (@(posedge clk) disable iff (reset)
		(clk_en && state_ff == tpsc_pkg::ST_ADDR && rx_full && addr_match && !line.stop_det && !line.start_det)
		|=> ack_pend_ff ##[1:64] (state_ff == tpsc_pkg::ST_ACK && !sda_oe_n))
		else $error("matched address not acknowledged");
	chk_addr_miss: assert property (@(posedge clk) disable iff (reset)
		(clk_en && state_ff == tpsc_pkg::ST_ADDR && rx_full && !addr_match && !line.stop_det && !line.start_det)
		|=> (state_ff == tpsc_pkg::ST_IDLE && sda_oe_n))
		else $error("foreign address not ignored");
	chk_write_ack: assert property (@(posedge clk) disable iff (reset)
		(clk_en && rx_done && !line.stop_det && !line.start_det) |=> ack_pend_ff)
		else $error("write byte not acknowledged");
	chk_div_pair: assert property (@(posedge clk) disable iff (reset)
		$changed(div_ff) |-> ($past(phase_ff) == tpsc_pkg::PH_DIV2 && $past(rx_done)))
		else $error("divider changed outside a complete pair");
	chk_ctrl_latch: assert property (@(posedge clk) disable iff (reset)
		(clk_en && rx_done && phase_ff == tpsc_pkg::PH_CLASS && rx_byte[7] && !line.stop_det && !line.start_det)
		|=> (ctrl_ff == $past(rx_byte) && phase_ff == tpsc_pkg::PH_BAND))
		else $error("control byte not latched at byte end");
	chk_stop_idle: assert property (@(posedge clk) disable iff (reset)
		(clk_en && line.stop_det) |=> (state_ff == tpsc_pkg::ST_IDLE && sda_oe_n))
		else $error("stop did not end the transfer");
	chk_rw_branch: assert property (@(posedge clk) disable iff (reset)
		(clk_en && state_ff == tpsc_pkg::ST_ACK && line.scl_fall && !line.stop_det && !line.start_det)
		|=> (state_ff == (rw_ff ? tpsc_pkg::ST_TX : tpsc_pkg::ST_RX)))
		else $error("direction bit not obeyed");
	chk_tx_release: assert property (@(posedge clk) disable iff (reset)
		(state_ff == tpsc_pkg::ST_TX) |-> (sda_oe_n == tx_ff[7]))
		else $error("status bit not on the data line");
	chk_ref_ratio: assert property (@(posedge clk) disable iff (reset)
		(ref_div_select == 2'h1) |-> (ref_divide_ratio == tpsc_pkg::RATIO_01))
		else $error("reference ratio decode wrong");
	chk_sink_forced: assert property (@(posedge clk) disable iff (reset)
		tuning_amp_disable |-> (pump_sink_only && !pump_source_only && !pump_off))
		else $error("amp disable did not force sink");

endmodule

/* rtl/tpsc_pkg.sv */
// Constants, field positions and state codes for the tuner synthesizer serial control
package tpsc_pkg;

	// ----------------------------------------
	// Address byte layout
	// ----------------------------------------
	localparam logic [4:0] ADDR_PREFIX     = 5'h18; // Fixed prefix 11000
	localparam int         ADDR_PREFIX_LSB = 3;     // Prefix sits in bits 7..3
	localparam int         ADDR_HW_LSB     = 1;     // Hardware address bits 2..1
	localparam int         ADDR_RW_BIT     = 0;     // Direction bit, 1 means read

	// ----------------------------------------
	// Data byte layout (bit 1 of the byte is bit 7 here)
	// ----------------------------------------
	localparam int TYPE_BIT = 7;   // 0 divider byte, 1 control or band byte
	localparam int CP_BIT   = 6;   // Control bit 2
	localparam int T2_BIT   = 5;   // Control bit 3
	localparam int T1_BIT   = 4;   // Control bit 4
	localparam int T0_BIT   = 3;   // Control bit 5
	localparam int RSA_BIT  = 2;   // Control bit 6
	localparam int RSB_BIT  = 1;   // Control bit 7
	localparam int OS_BIT   = 0;   // Control bit 8
	localparam int BAND_W   = 4;   // Band port bits in the low nibble
	localparam int DIV_W    = 15;  // Divider word width
	localparam int BYTE_W   = 8;   // Bits per serial byte

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [14:0] DIV_RESET  = 15'h0000;
	localparam logic [7:0]  CTRL_RESET = 8'h87;    // Low pump, divide 64, amp off
	localparam logic [3:0]  BAND_RESET = 4'h0;     // All band ports off
	localparam logic        POR_RESET  = 1'b1;     // Flag set after power-on
	localparam logic [5:0]  STATUS_ONES = 6'h3f;   // Low status bits read as one

	// ----------------------------------------
	// Reference divide ratios per select code
	// ----------------------------------------
	localparam logic [6:0] RATIO_00 = 7'h50;  // 80
	localparam logic [6:0] RATIO_01 = 7'h1c;  // 28
	localparam logic [6:0] RATIO_10 = 7'h18;  // 24
	localparam logic [6:0] RATIO_11 = 7'h40;  // 64

	// ----------------------------------------
	// Test-mode decode vector positions
	// ----------------------------------------
	localparam int DEC_OFF  = 4;  // Charge pump off
	localparam int DEC_SINK = 3;  // Sink current only
	localparam int DEC_SRC  = 2;  // Source current only
	localparam int DEC_REF  = 1;  // Reference signal out
	localparam int DEC_HALF = 0;  // Half counter out

	// ----------------------------------------
	// State codes
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_ADDR  = 6'h02,
		ST_ACK   = 6'h04,
		ST_RX    = 6'h08,
		ST_TX    = 6'h10,
		ST_TXACK = 6'h20
	} tpsc_state_e;

	typedef enum logic [2:0] {
		PH_CLASS = 3'h1,
		PH_DIV2  = 3'h2,
		PH_BAND  = 3'h4
	} tpsc_phase_e;

endpackage

/* rtl/tpsc_line_if.sv */
// Conditioned bus line events passed from the pin synchroniser to the controller
`timescale 1ns/1ps
interface tpsc_line_if;
	logic       scl_rise;   // Clock line rose
	logic       scl_fall;   // Clock line fell
	logic       sda_lvl;    // Synchronised data level
	logic       start_det;  // Start or repeated start seen
	logic       stop_det;   // Stop seen
	logic       lock_lvl;   // Synchronised lock detect
	logic [1:0] hw_addr;    // Synchronised hardware address bits

	modport src (output scl_rise, scl_fall, sda_lvl, start_det, stop_det, lock_lvl, hw_addr);
	modport snk (input scl_rise, scl_fall, sda_lvl, start_det, stop_det, lock_lvl, hw_addr);
endinterface

/* rtl/tpsc_pin_sync.sv */
// Two-flop synchronisers and edge, start and stop detection for the bus pins
`timescale 1ns/1ps
module tpsc_pin_sync (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       lock_in,
	input  wire logic [1:0] addr_sel_in,
	tpsc_line_if.src        line
);

	// ----------------------------------------
	// Synchroniser chain
	// ----------------------------------------
	logic [4:0] meta_ff;    // First stage, read only by sync_ff
	logic [4:0] sync_ff;    // Second stage: scl, sda, lock, addr1, addr0
	logic [1:0] prev_ff;    // Previous scl and sda for edge finding
	logic [4:0] nxt_meta;
	logic [4:0] nxt_sync;
	logic [1:0] nxt_prev;

	// Next values of the chain
	always_comb
	begin
		nxt_meta = {scl_in, sda_in, lock_in, addr_sel_in};
		nxt_sync = meta_ff;
		nxt_prev = sync_ff[4:3];
	end

	// Idle bus reads high, so lines reset high to avoid a false start
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_ff <= 5'h18;
			sync_ff <= 5'h18;
			prev_ff <= 2'h3;
		end
		else if (clk_en)
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	// ----------------------------------------
	// Line events
	// ----------------------------------------
	assign line.scl_rise  = sync_ff[4] & ~prev_ff[1];
	assign line.scl_fall  = ~sync_ff[4] & prev_ff[1];
	// Data moving while clock stays high marks start or stop
	assign line.start_det = sync_ff[4] & prev_ff[1] & prev_ff[0] & ~sync_ff[3];
	assign line.stop_det  = sync_ff[4] & prev_ff[1] & ~prev_ff[0] & sync_ff[3];
	assign line.sda_lvl   = sync_ff[3];
	assign line.lock_lvl  = sync_ff[2];
	assign line.hw_addr   = sync_ff[1:0];

endmodule

/* rtl/tpsc_rx_shift.sv */
// Serial-in shift register with bit counter and byte-complete pulse
`timescale 1ns/1ps
module tpsc_rx_shift #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             clear,
	input  wire logic             shift_en,
	input  wire logic             bit_in,
	output logic      [WIDTH-1:0] data,
	output logic                  full
);

	localparam int CW = $clog2(WIDTH);

	// ----------------------------------------
	// Shift state
	// ----------------------------------------
	logic [WIDTH-1:0] data_ff;   // Received bits, first bit ends in the top
	logic [CW-1:0]    cnt_ff;    // Bits taken so far
	logic             full_ff;   // One-cycle pulse when a byte completes
	logic [WIDTH-1:0] nxt_data;
	logic [CW-1:0]    nxt_cnt;
	logic             nxt_full;

	// Clear wins over a shift so a start always realigns the byte
	always_comb
	begin
		nxt_data = data_ff;
		nxt_cnt  = cnt_ff;
		nxt_full = 1'b0;
		if (clear)
			nxt_cnt = '0;
		else if (shift_en)
		begin
			nxt_data = {data_ff[WIDTH-2:0], bit_in};
			if (cnt_ff == CW'(WIDTH - 1))
			begin
				nxt_cnt  = '0;
				nxt_full = 1'b1;
			end
			else
				nxt_cnt = cnt_ff + CW'(1);
		end
	end

	// Register the shift state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			data_ff <= '0;
			cnt_ff  <= '0;
			full_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			data_ff <= nxt_data;
			cnt_ff  <= nxt_cnt;
			full_ff <= nxt_full;
		end
	end

	assign data = data_ff;
	assign full = full_ff;

endmodule

/* dv/tpsc_bus_master.sv */
// Bus master model that drives the serial clock and data lines
`timescale 1ns/1ps
module tpsc_bus_master (
	input  wire logic clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda
);
	// Both lines idle high, and the clock stands still between frames
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Quarter bit of two clocks, so a bit takes 320 ns
	task automatic q(input logic c, input logic d);
		@(posedge clk);
		scl <= c;
		sda <= d;
		@(posedge clk);
	endtask
	// Start is (1,0) and stop is (0,1); data takes the first level while the clock is low, the second while it is high
	task automatic cond(input logic a, input logic b);
		q(1'b0, sda);
		q(1'b0, a);
		q(1'b1, a);
		q(1'b1, b);
	endtask
	// Eight bits MSB first, then the acknowledge slot; data changes a quarter after the fall
	task automatic xfer(input logic [8:0] b, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			for (int j = 0; j < 4; j++)
				q(1'(j >> 1), j == 0 ? sda : b[i]);
			r[i] = sda_w;
		end
	endtask
endmodule

/* dv/tb_tuner_pll_serial_control.sv */
// Self-checking bench for the synthesizer serial control
`timescale 1ns/1ps
module tb_tuner_pll_serial_control;
	logic        clk = 1'b0, reset = 1'b1, lock_in = 1'b0;
	logic        scl, sda_m, sda_out, sda_oe_n, por;
	logic [1:0]  hw = 2'h2, rs;
	logic [3:0]  bp, eb;
	logic [4:0]  cf, dc;
	logic [6:0]  rt;
	logic [7:0]  fcb, cb;
	logic [8:0]  r;
	logic [14:0] dw, dv, ed = 15'h0000;
	int          mismatches = 0, checks_done = 0, seed = 68;
	logic [6:0]  rat [4] = '{7'h50, 7'h1c, 7'h18, 7'h40}; // Ratio per select code
	wire         sda_w = sda_m & (sda_oe_n | sda_out);   // Open drain, high once released
	tpsc_serial_ctrl u_dut (.clk(clk), .reset(reset), .clk_en(1'b1), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_in(hw), .lock_in(lock_in), .divider_word(dw),
		.function_control_byte(fcb), .band_port(bp), .pump_current_select(cf[4]), .test_select_hi(cf[3]),
		.test_select_mid(cf[2]), .test_select_lo(cf[1]), .ref_div_select(rs), .ref_divide_ratio(rt),
		.tuning_amp_disable(cf[0]), .pump_off(dc[4]), .pump_sink_only(dc[3]), .pump_source_only(dc[2]),
		.ref_signal_out_en(dc[1]), .half_counter_out_en(dc[0]), .por_flag(por));
	tpsc_bus_master u_m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_m));
	initial forever #20 clk = ~clk;
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Decode {off, sink, source, ref, half}; amp disable forces sink, blocks off and source only
	function automatic logic [4:0] f_dec(input logic [7:0] c);
		logic [4:0] t;
		t = c[5:4] == 2'h1 ? 5'h10 : c[5:3] == 3'h6 ? 5'h08 : c[5:3] == 3'h7 ? 5'h04 :
			c[5:3] == 3'h4 ? 5'h02 : c[5:3] == 3'h5 ? 5'h01 : 5'h00;
		return c[0] ? ((t & 5'h03) | 5'h08) : t;
	endfunction
	task automatic settle(input logic [7:0] c, input logic [3:0] b);
		chk({dw, fcb, bp, cf, rs, rt, dc}, {ed, c, b, c[6:3], c[0], c[2:1], rat[c[2:1]], f_dec(c)});
	endtask
	// One written byte; the device must pull the acknowledge slot low
	task automatic wr(input logic [7:0] b);
		u_m.xfer({b, 1'b1}, r);
		chk(r[0], 1'b0);
	endtask
	// Status read; with the flag still set the master acks once and reads a second byte
	task automatic rd(input logic p);
		u_m.cond(1'b1, 1'b0);
		wr({5'h18, hw, 1'b1});
		u_m.xfer({8'hff, !p}, r);
		chk(r[8:1], {p, lock_in, 6'h3f});
		if (p)
		begin
			u_m.xfer(9'h1ff, r);
			chk(r[8:1], {1'b0, lock_in, 6'h3f});
		end
		u_m.cond(1'b0, 1'b1);
		chk(por, 1'b0);
	endtask
	task automatic give_verdict();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		settle(8'h87, 4'h0);
		chk(por, 1'b1);
		// Wrong hardware bits must not be answered
		u_m.cond(1'b1, 1'b0);
		u_m.xfer({5'h18, ~hw, 2'h1}, r);
		u_m.cond(1'b0, 1'b1);
		chk(r[0], 1'b1);
		rd(1'b1);
		// Every test and ratio code, random data, abort on a half divider pair
		for (int k = 0; k < 16; k++)
		begin
			hw <= 2'($random(seed));
			lock_in <= 1'($random(seed));
			cb = {1'b1, 7'($random(seed))};
			cb[5:0] = {k[2:0], k[1:0], k[3]};
			dv = 15'($random(seed));
			eb = 4'($random(seed));
			u_m.cond(1'b1, 1'b0);
			wr({5'h18, hw, 1'b0});
			wr({1'b0, dv[14:8]});
			chk(dw, ed);
			wr(dv[7:0]);
			ed = dv;
			chk(dw, ed);
			wr(cb);
			wr({4'($random(seed)), eb});
			wr({1'b0, 7'($random(seed))});
			u_m.cond(1'b0, 1'b1);
			settle(cb, eb);
			rd(1'b0);
		end
		give_verdict();
	end
endmodule
